/* design/synth_freq_ctrl.sv */
// Frequency control: registers, hop retune sequencing and modulator
`timescale 1ns/1ps
`default_nettype none
module synth_freq_ctrl
    import synth_freq_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = PLL_SETTLE_CYCLES_DEF
)(
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    input  wire logic [6:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    output var  logic [7:0]   reg_rdata_o,
    input  wire logic         tx_on_i,
    input  wire logic         rx_on_i,
    input  wire logic         tx_fifo_mode_i,
    input  wire logic         tx_packet_active_i,
    input  wire logic         tx_data_i,
    input  wire logic         fsk_enable_i,
    input  wire logic [8:0]   deviation_word_i,
    output var  logic [6:0]   synth_int_o,
    output var  logic [15:0]  synth_frac_o,
    output var  logic [6:0]   dsm_div_o,
    output var  logic         dsm_tick_o,
    output var  logic         band_high_o,
    output var  logic         output_halve_o,
    output var  radio_state_e radio_state_o,
    output var  logic         synth_update_o
);
    typedef struct packed {
        freq_regs_s   regs;
        logic [7:0]   act_channel;
        logic [7:0]   act_step;
        logic         hop_pending;
        radio_state_e fsm;
        logic         resume_rx;
        logic [15:0]  settle_cnt;
        logic [4:0]   ref_div;
        logic         ref_tick;
        logic [16:0]  dsm_acc;
        logic [6:0]   dsm_div;
        synth_word_s  word;
        logic         update;
        logic [7:0]   rdata;
    } ctrl_state_s;

    localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

    ctrl_state_s state;
    ctrl_state_s next_state;
    freq_regs_s  calc_regs;
    synth_word_s calc_word;
    logic        hop_write;
    logic        freq_write;
    logic        defer;
    logic        in_link;

    // The calculator sees the active hop copy so deferred writes wait
    always_comb begin
        calc_regs             = state.regs;
        calc_regs.hop_channel = state.act_channel;
        calc_regs.hop_step    = state.act_step;
    end

    synth_word_calc u_calc (
        .clk_sys_i        (clk_sys_i),
        .sys_rst_i        (sys_rst_i),
        .regs_i           (calc_regs),
        .rx_shift_i       (state.fsm == ST_RX ||
                           (state.fsm == ST_RETUNE && state.resume_rx)),
        .fsk_active_i     (fsk_enable_i && state.fsm == ST_TX),
        .tx_data_i        (tx_data_i),
        .deviation_word_i (deviation_word_i),
        .word_o           (calc_word)
    );

    always_comb begin
        next_state = state;
        next_state.update = 1'b0;
        hop_write = reg_wr_i && (reg_addr_i == ADDR_HOP_CHANNEL_NUMBER ||
                                 reg_addr_i == ADDR_HOP_STEP_SIZE);
        freq_write = reg_wr_i && (reg_addr_i >= ADDR_FREQ_OFFSET_LOW &&
                                  reg_addr_i <= ADDR_CARRIER_FRACTION_LOW);
        in_link = state.fsm == ST_TX || state.fsm == ST_RX;
        defer = tx_fifo_mode_i && tx_packet_active_i &&
                state.fsm == ST_TX;

        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_FREQ_OFFSET_LOW: begin
                    next_state.regs.offset_word[7:0] = reg_wdata_i;
                end
                ADDR_FREQ_OFFSET_HIGH: begin
                    next_state.regs.offset_word[9:8] = reg_wdata_i[1:0];
                end
                ADDR_BAND_SELECTION: begin
                    next_state.regs.side_band = reg_wdata_i[SIDE_BAND_BIT];
                    next_state.regs.band_high = reg_wdata_i[HIGH_BAND_BIT];
                    next_state.regs.band_integer =
                        (reg_wdata_i[BAND_INT_MSB:0] > BAND_INT_MAX)
                        ? BAND_INT_MAX
                        : reg_wdata_i[BAND_INT_MSB:0];
                end
                ADDR_CARRIER_FRACTION_HIGH: begin
                    next_state.regs.carrier_fraction[15:8] = reg_wdata_i;
                end
                ADDR_CARRIER_FRACTION_LOW: begin
                    next_state.regs.carrier_fraction[7:0] = reg_wdata_i;
                end
                ADDR_HOP_CHANNEL_NUMBER: begin
                    next_state.regs.hop_channel = reg_wdata_i;
                end
                ADDR_HOP_STEP_SIZE: begin
                    next_state.regs.hop_step = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end

        // Hop values go live at once unless a FIFO packet is on air
        if (hop_write) begin
            if (defer) begin
                next_state.hop_pending = 1'b1;
            end else begin
                next_state.act_channel = next_state.regs.hop_channel;
                next_state.act_step    = next_state.regs.hop_step;
            end
        end

        // Register reads, answered one cycle later
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_FREQ_OFFSET_LOW: begin
                    next_state.rdata = state.regs.offset_word[7:0];
                end
                ADDR_FREQ_OFFSET_HIGH: begin
                    next_state.rdata = OFFSET_HIGH_RW_MASK &
                        8'(state.regs.offset_word[9:8]);
                end
                ADDR_BAND_SELECTION: begin
                    next_state.rdata = BAND_SEL_RW_MASK &
                        {1'b0, state.regs.side_band, state.regs.band_high,
                         state.regs.band_integer};
                end
                ADDR_CARRIER_FRACTION_HIGH: begin
                    next_state.rdata = state.regs.carrier_fraction[15:8];
                end
                ADDR_CARRIER_FRACTION_LOW: begin
                    next_state.rdata = state.regs.carrier_fraction[7:0];
                end
                ADDR_HOP_CHANNEL_NUMBER: begin
                    next_state.rdata = state.regs.hop_channel;
                end
                ADDR_HOP_STEP_SIZE: begin
                    next_state.rdata = state.regs.hop_step;
                end
                default: begin
                    next_state.rdata = READ_UNMAPPED;
                end
            endcase
        end

        // Operating state sequencing
        case (state.fsm)
            ST_IDLE: begin
                if (tx_on_i) begin
                    next_state.fsm = ST_TX;
                end else if (rx_on_i) begin
                    next_state.fsm = ST_RX;
                end
            end
            ST_TX, ST_RX: begin
                if (!tx_on_i && !rx_on_i) begin
                    next_state.fsm = ST_IDLE;
                end else if ((hop_write && !defer) ||
                             (state.hop_pending && !defer)) begin
                    next_state.fsm        = ST_RETUNE;
                    next_state.resume_rx  = state.fsm == ST_RX;
                    next_state.settle_cnt = SETTLE_LAST;
                    if (state.hop_pending) begin
                        next_state.hop_pending = 1'b0;
                        next_state.act_channel =
                            next_state.regs.hop_channel;
                        next_state.act_step = next_state.regs.hop_step;
                    end
                end else if (tx_on_i && state.fsm == ST_RX) begin
                    next_state.fsm = ST_TX;
                end else if (!tx_on_i && state.fsm == ST_TX) begin
                    next_state.fsm = ST_RX;
                end
            end
            ST_RETUNE: begin
                // Only tuning: PA and receiver are off while the loop settles
                if (state.settle_cnt == '0) begin
                    if (!tx_on_i && !rx_on_i) begin
                        next_state.fsm = ST_IDLE;
                    end else begin
                        next_state.fsm = state.resume_rx ? ST_RX
                                                         : ST_TX;
                    end
                end else begin
                    next_state.settle_cnt = state.settle_cnt - 16'h0001;
                end
            end
            default: begin
                next_state.fsm = ST_IDLE;
            end
        endcase

        // Pending change with no packet left to finish
        if (state.hop_pending && !in_link && state.fsm != ST_RETUNE) begin
            next_state.hop_pending = 1'b0;
            next_state.act_channel = next_state.regs.hop_channel;
            next_state.act_step    = next_state.regs.hop_step;
        end

        // Division word tracks the calculator every cycle
        if (calc_word != state.word || freq_write) begin
            next_state.update = 1'b1;
        end
        next_state.word = calc_word;

        // 10 MHz modulator tick from the system clock
        next_state.ref_tick = 1'b0;
        if (state.ref_div == REF_DIV_LAST) begin
            next_state.ref_div  = '0;
            next_state.ref_tick = 1'b1;
        end else begin
            next_state.ref_div = state.ref_div + 5'h01;
        end

        // First order modulo accumulator; carry bumps the integer divide
        if (state.ref_tick) begin
            next_state.dsm_acc = state.dsm_acc + 17'(state.word.div_frac);
            if (next_state.dsm_acc >= 17'(FRAC_MODULUS)) begin
                next_state.dsm_acc = next_state.dsm_acc
                    - 17'(FRAC_MODULUS);
                next_state.dsm_div = state.word.div_int + 7'h01;
            end else begin
                next_state.dsm_div = state.word.div_int;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= '0;
            state.regs.offset_word <=
                {RST_FREQ_OFFSET_HIGH[1:0], RST_FREQ_OFFSET_LOW};
            state.regs.side_band <= RST_BAND_SELECTION[SIDE_BAND_BIT];
            state.regs.band_high <= RST_BAND_SELECTION[HIGH_BAND_BIT];
            state.regs.band_integer <= RST_BAND_SELECTION[BAND_INT_MSB:0];
            state.regs.carrier_fraction <=
                {RST_CARRIER_FRACTION_HIGH, RST_CARRIER_FRACTION_LOW};
            state.regs.hop_channel <= RST_HOP_CHANNEL_NUMBER;
            state.regs.hop_step <= RST_HOP_STEP_SIZE;
            state.act_channel <= RST_HOP_CHANNEL_NUMBER;
            state.act_step <= RST_HOP_STEP_SIZE;
            state.fsm <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata_o    = state.rdata;
    assign synth_int_o    = state.word.div_int;
    assign synth_frac_o   = state.word.div_frac;
    assign dsm_div_o      = state.dsm_div;
    assign dsm_tick_o     = state.ref_tick;
    assign band_high_o    = state.regs.band_high;
    assign output_halve_o = ~state.regs.band_high;
    assign radio_state_o  = state.fsm;
    assign synth_update_o = state.update;
endmodule : synth_freq_ctrl
`default_nettype wire

/* design/synth_freq_pkg.sv */
// Shared constants, types and register map of the synthesizer frequency control
package synth_freq_pkg;
    // Register addresses on the byte register port
    localparam logic [6:0] ADDR_FREQ_OFFSET_LOW       = 7'h73;
    localparam logic [6:0] ADDR_FREQ_OFFSET_HIGH      = 7'h74;
    localparam logic [6:0] ADDR_BAND_SELECTION        = 7'h75;
    localparam logic [6:0] ADDR_CARRIER_FRACTION_HIGH = 7'h76;
    localparam logic [6:0] ADDR_CARRIER_FRACTION_LOW  = 7'h77;
    localparam logic [6:0] ADDR_HOP_CHANNEL_NUMBER    = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP_SIZE         = 7'h7A;

    // Reset values and the value read at unmapped addresses
    localparam logic [7:0] RST_FREQ_OFFSET_LOW       = 8'h00;
    localparam logic [7:0] RST_FREQ_OFFSET_HIGH      = 8'h00;
    localparam logic [7:0] RST_BAND_SELECTION        = 8'h35;
    localparam logic [7:0] RST_CARRIER_FRACTION_HIGH = 8'hBB;
    localparam logic [7:0] RST_CARRIER_FRACTION_LOW  = 8'h80;
    localparam logic [7:0] RST_HOP_CHANNEL_NUMBER    = 8'h00;
    localparam logic [7:0] RST_HOP_STEP_SIZE         = 8'h00;
    localparam logic [7:0] READ_UNMAPPED             = 8'h00;

    // Field layout of band_selection, plus the freq offset high read mask
    localparam int BAND_INT_MSB = 4;
    localparam int HIGH_BAND_BIT = 5;
    localparam int SIDE_BAND_BIT = 6;
    localparam logic [7:0] BAND_SEL_RW_MASK    = 8'h7F;
    localparam logic [7:0] OFFSET_HIGH_RW_MASK = 8'h03;
    localparam logic [4:0] BAND_INT_MAX        = 5'h17;

    // Synthesizer arithmetic, in fraction steps of the loop
    localparam logic [25:0] FRAC_MODULUS  = 26'h000FA00;  // 64000
    localparam logic [5:0]  BAND_INT_BASE = 6'h18;        // 24
    localparam int          HOP_UNIT_SHIFT = 6;   // 10 kHz = 64 steps
    localparam int          DEV_UNIT_SHIFT = 2;   // 625 Hz = 4 steps
    localparam logic [25:0] RX_IF_SHIFT   = 26'h0001770;  // 6000 steps

    // Timing: 200 MHz system clock, 10 MHz modulator tick
    localparam int CLK_PERIOD_PS = 5000;
    localparam int REF_PERIOD_PS = 100000;
    localparam int REF_DIV_CYCLES = REF_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [4:0] REF_DIV_LAST = 5'(REF_DIV_CYCLES - 1);
    localparam int PLL_SETTLE_NS = 200000;
    localparam int PLL_SETTLE_CYCLES_DEF =
        (PLL_SETTLE_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TX,
        ST_RX,
        ST_RETUNE
    } radio_state_e;

    typedef struct packed {
        logic [9:0]  offset_word;
        logic        side_band;
        logic        band_high;
        logic [4:0]  band_integer;
        logic [15:0] carrier_fraction;
        logic [7:0]  hop_channel;
        logic [7:0]  hop_step;
    } freq_regs_s;

    typedef struct packed {
        logic [6:0]  div_int;
        logic [15:0] div_frac;
    } synth_word_s;
endpackage : synth_freq_pkg

/* design/synth_word_calc.sv */
// Registered division word from the frequency settings
`timescale 1ns/1ps
`default_nettype none
module synth_word_calc
    import synth_freq_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire freq_regs_s  regs_i,
    input  wire logic        rx_shift_i,
    input  wire logic        fsk_active_i,
    input  wire logic        tx_data_i,
    input  wire logic [8:0]  deviation_word_i,
    output var  synth_word_s word_o
);
    synth_word_s state;
    synth_word_s next_state;

    logic signed [25:0] total;
    logic [25:0]        hop_steps;
    logic [25:0]        dev_steps;
    logic [6:0]         quot;

    always_comb begin
        // Terms are in loop steps; output-referred sizes halve in high band
        hop_steps = 26'(regs_i.hop_step * regs_i.hop_channel)
            << HOP_UNIT_SHIFT;
        hop_steps = hop_steps >> regs_i.band_high;
        dev_steps = 26'(deviation_word_i) << DEV_UNIT_SHIFT;
        dev_steps = dev_steps >> regs_i.band_high;
        total = signed'(26'(regs_i.band_integer + BAND_INT_BASE)
            * FRAC_MODULUS);
        total = total + signed'(26'(regs_i.carrier_fraction));
        total = total + 26'(signed'(regs_i.offset_word));
        total = total + signed'(hop_steps);
        if (fsk_active_i) begin
            total = tx_data_i ? total + signed'(dev_steps)
                              : total - signed'(dev_steps);
        end
        if (rx_shift_i) begin
            total = total - signed'(RX_IF_SHIFT >> regs_i.band_high);
        end
        quot = 7'(unsigned'(total) / FRAC_MODULUS);
        next_state.div_int  = quot;
        next_state.div_frac = 16'(unsigned'(total)
            - 26'(quot) * FRAC_MODULUS);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign word_o = state;
endmodule : synth_word_calc
`default_nettype wire

/* dv/synth_freq_ctrl_assertions.sv */
// Port checker for the synthesizer frequency control
`timescale 1ns/1ps
`default_nettype none
module synth_freq_ctrl_assertions
    import synth_freq_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = 8
)(
    input wire logic         clk_sys_i,
    input wire logic         sys_rst_i,
    input wire logic         reg_wr_i,
    input wire logic         reg_rd_i,
    input wire logic [6:0]   reg_addr_i,
    input wire logic [7:0]   reg_wdata_i,
    input wire logic [7:0]   reg_rdata_o,
    input wire logic         tx_on_i,
    input wire logic         rx_on_i,
    input wire logic         tx_fifo_mode_i,
    input wire logic         tx_packet_active_i,
    input wire logic         tx_data_i,
    input wire logic         fsk_enable_i,
    input wire logic [8:0]   deviation_word_i,
    input wire logic [6:0]   synth_int_o,
    input wire logic [15:0]  synth_frac_o,
    input wire logic [6:0]   dsm_div_o,
    input wire logic         dsm_tick_o,
    input wire logic         band_high_o,
    input wire logic         output_halve_o,
    input wire radio_state_e radio_state_o,
    input wire logic         synth_update_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    logic [4:0]  tick_cnt;
    logic        tick_seen;
    int unsigned rt_cnt;

    // Spacing checked from the second tick
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tick_cnt  <= 5'h00;
            tick_seen <= 1'b0;
            rt_cnt    <= 0;
        end else begin
            tick_cnt  <= dsm_tick_o ? 5'h00 : tick_cnt + 5'h01;
            tick_seen <= tick_seen | dsm_tick_o;
            rt_cnt    <= (radio_state_o == ST_RETUNE) ? rt_cnt + 1 : 0;
        end
    end

    sequence s_hop_wr;
        reg_wr_i && (reg_addr_i == ADDR_HOP_CHANNEL_NUMBER
            || reg_addr_i == ADDR_HOP_STEP_SIZE);
    endsequence
    sequence s_retune_exit;
        radio_state_o == ST_RETUNE ##1 radio_state_o != ST_RETUNE;
    endsequence
    sequence s_sat_wr;
        reg_wr_i && reg_addr_i == ADDR_BAND_SELECTION
            && reg_wdata_i[4:0] > BAND_INT_MAX;
    endsequence
    sequence s_band_rd;
        reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_BAND_SELECTION;
    endsequence

    property p_tick_period;
        dsm_tick_o && tick_seen |-> tick_cnt == REF_DIV_LAST;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("modulator tick spacing wrong");
    property p_frac_range;
        synth_frac_o < 16'hFA00;
    endproperty
    a_frac_range: assert property (p_frac_range)
        else $error("loop fraction beyond modulus");
    property p_dsm_div;
        dsm_tick_o |=> dsm_div_o == $past(synth_int_o)
            || dsm_div_o == $past(synth_int_o) + 7'h01;
    endproperty
    a_dsm_div: assert property (p_dsm_div)
        else $error("modulator division off");
    property p_halve;
        (output_halve_o != band_high_o) and (reg_wr_i && reg_addr_i ==
            ADDR_BAND_SELECTION |=> band_high_o == $past(reg_wdata_i[5]));
    endproperty
    a_halve: assert property (p_halve)
        else $error("output halver not tied to band flag");
    property p_sat;
        s_sat_wr ##1 s_band_rd |=> reg_rdata_o[4:0] == BAND_INT_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("band integer not saturated");
    property p_offset_mask;
        reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_FREQ_OFFSET_HIGH
            |=> reg_rdata_o[7:2] == 6'h00;
    endproperty
    a_offset_mask: assert property (p_offset_mask)
        else $error("offset high byte unused bits set");
    property p_retune_in;
        s_hop_wr ##0 (radio_state_o == ST_RX || (radio_state_o == ST_TX
            && !(tx_fifo_mode_i && tx_packet_active_i)))
            |=> radio_state_o == ST_RETUNE;
    endproperty
    a_retune_in: assert property (p_retune_in)
        else $error("hop write did not start retune");
    property p_retune_len;
        s_retune_exit |-> rt_cnt == SETTLE_CYCLES;
    endproperty
    a_retune_len: assert property (p_retune_len)
        else $error("retune length wrong");
    property p_defer;
        s_hop_wr ##0 (radio_state_o == ST_TX && tx_fifo_mode_i
            && tx_packet_active_i) |=> (radio_state_o == ST_TX)[*2];
    endproperty
    a_defer: assert property (p_defer)
        else $error("hop change not deferred in packet");
    property p_update;
        reg_wr_i && reg_addr_i >= ADDR_FREQ_OFFSET_LOW
            && reg_addr_i <= ADDR_CARRIER_FRACTION_LOW
            |-> ##[1:3] synth_update_o;
    endproperty
    a_update: assert property (p_update)
        else $error("frequency write gave no update");
endmodule // synth_freq_ctrl_assertions

bind synth_freq_ctrl synth_freq_ctrl_assertions #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (
    .clk_sys_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .tx_on_i, .rx_on_i, .tx_fifo_mode_i,
    .tx_packet_active_i, .tx_data_i, .fsk_enable_i, .deviation_word_i,
    .synth_int_o, .synth_frac_o, .dsm_div_o, .dsm_tick_o, .band_high_o,
    .output_halve_o, .radio_state_o, .synth_update_o
);
`default_nettype wire

/* dv/host_mcu_model.sv */
// Host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] reg_rdata_i,
    output var  logic       reg_wr_o,
    output var  logic       reg_rd_o,
    output var  logic [6:0] reg_addr_o,
    output var  logic [7:0] reg_wdata_o
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
    // One write is one clock cycle
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_rd_o    = 1'b0;
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        reg_wr_o   = 1'b0;
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(posedge clk_sys_i);
        #1;
        d = reg_rdata_i;
    endtask
    // Released lines flip so a stale value never passes for a request
    task automatic idle();
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
        @(posedge clk_sys_i);
        #1;
    endtask
endmodule // host_mcu_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the synthesizer frequency control
`timescale 1ns/1ps
`default_nettype none
module testbench
    import synth_freq_pkg::*;
;
    localparam int unsigned SETTLE = 8;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1;
    logic reg_wr_i, reg_rd_i;
    logic [6:0] reg_addr_i, synth_int_o, dsm_div_o;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic tx_on_i = 0, rx_on_i = 0, tx_fifo_mode_i = 0;
    logic tx_packet_active_i = 0, tx_data_i = 0, fsk_enable_i = 0;
    logic [8:0] deviation_word_i = 9'h020;
    logic [15:0] synth_frac_o;
    logic dsm_tick_o, band_high_o, output_halve_o, synth_update_o;
    radio_state_e radio_state_o;
    int miscompares = 0, n_compared = 0;
    int bi = 21, hb = 1, fr = 48000, off = 0, st = 0, ch = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    synth_freq_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (
        .clk_sys_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .tx_on_i, .rx_on_i, .tx_fifo_mode_i,
        .tx_packet_active_i, .tx_data_i, .fsk_enable_i, .deviation_word_i,
        .synth_int_o, .synth_frac_o, .dsm_div_o, .dsm_tick_o, .band_high_o,
        .output_halve_o, .radio_state_o, .synth_update_o);
    host_mcu_model host (.clk_sys_i, .reg_rdata_i(reg_rdata_o),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic [22:0] exp_word(bit rx, int dv);
        longint w;
        w = (bi + 24) * 64000 + fr + ((off >= 512) ? off - 1024 : off)
            + ((st * ch * 64) >> hb) + dv - (rx ? (6000 >> hb) : 0);
        return {7'(w / 64000), 16'(w % 64000)};
    endfunction
    task automatic settle_word(input bit rx, input int dv);
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk(32'({synth_int_o, synth_frac_o}), 32'(exp_word(rx, dv)));
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(32'(d), 32'(e));
    endtask
    task automatic wait_state(input radio_state_e s);
        int n;
        for (n = 0; radio_state_o !== s && n < 50; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (n >= 50) begin
            miscompares++;
            results();
        end
    endtask

    task automatic t_reset();
        logic [7:0] v[9] = '{READ_UNMAPPED, RST_FREQ_OFFSET_LOW,
            RST_FREQ_OFFSET_HIGH, RST_BAND_SELECTION,
            RST_CARRIER_FRACTION_HIGH, RST_CARRIER_FRACTION_LOW,
            READ_UNMAPPED, RST_HOP_CHANNEL_NUMBER, RST_HOP_STEP_SIZE};
        for (int i = 0; i < 9; i++) rdchk(7'h72 + 7'(i), v[i]);
        host.idle();
        settle_word(1'b0, 0);
        chk(32'(band_high_o), 32'h1);
        $display("reset test done");
    endtask
    task automatic t_band();
        host.wr(ADDR_BAND_SELECTION, 8'hFF);
        rdchk(ADDR_BAND_SELECTION, 8'h77);
        bi = 23;
        settle_word(1'b0, 0);
        host.wr(ADDR_BAND_SELECTION, 8'h0A);
        host.idle();
        bi = 10;
        hb = 0;
        settle_word(1'b0, 0);
        chk(32'(output_halve_o), 32'h1);
        $display("band test done");
    endtask
    task automatic t_offset();
        host.wr(ADDR_FREQ_OFFSET_HIGH, 8'hFF);
        rdchk(ADDR_FREQ_OFFSET_HIGH, 8'h03);
        host.wr(ADDR_FREQ_OFFSET_LOW, 8'h60);
        host.wr(ADDR_CARRIER_FRACTION_HIGH, 8'h12);
        host.wr(ADDR_CARRIER_FRACTION_LOW, 8'h34);
        host.idle();
        off = 'h360;
        fr = 'h1234;
        settle_word(1'b0, 0);
        host.wr(ADDR_HOP_STEP_SIZE, 8'h64);
        host.wr(ADDR_HOP_CHANNEL_NUMBER, 8'h05);
        host.idle();
        chk(32'(radio_state_o), 32'(ST_IDLE));
        st = 100;
        ch = 5;
        settle_word(1'b0, 0);
        $display("hop test done");
    endtask
    task automatic t_retune();
        int n;
        logic [6:0] a[2] = '{ADDR_HOP_STEP_SIZE, ADDR_HOP_CHANNEL_NUMBER};
        rx_on_i = 1'b1;
        settle_word(1'b1, 0);
        for (int i = 0; i < 2; i++) begin
            host.wr(a[i], 8'hFF);
            chk(32'(radio_state_o), 32'(ST_RETUNE));
            host.idle();
            for (n = 1; radio_state_o === ST_RETUNE && n < 100; n++) begin
                @(posedge clk_sys_i);
                #1;
            end
            chk(32'(n), SETTLE);
            chk(32'(radio_state_o), 32'(ST_RX));
        end
        st = 255;
        ch = 255;
        settle_word(1'b1, 0);
        rx_on_i = 1'b0;
        $display("retune test done");
    endtask
    task automatic t_defer();
        tx_on_i = 1'b1;
        tx_fifo_mode_i = 1'b1;
        tx_packet_active_i = 1'b1;
        wait_state(ST_TX);
        host.wr(ADDR_HOP_CHANNEL_NUMBER, 8'h02);
        rdchk(ADDR_HOP_CHANNEL_NUMBER, 8'h02);
        host.idle();
        chk(32'(radio_state_o), 32'(ST_TX));
        settle_word(1'b0, 0);
        tx_packet_active_i = 1'b0;
        wait_state(ST_RETUNE);
        wait_state(ST_TX);
        ch = 2;
        settle_word(1'b0, 0);
        $display("defer test done");
    endtask
    task automatic t_fsk();
        fsk_enable_i = 1'b1;
        tx_data_i = 1'b1;
        settle_word(1'b0, 128);
        tx_data_i = 1'b0;
        settle_word(1'b0, -128);
        host.wr(ADDR_BAND_SELECTION, 8'h2A);
        host.idle();
        hb = 1;
        settle_word(1'b0, -64);
        chk(32'(radio_state_o), 32'(ST_TX));
        tx_on_i = 1'b0;
        $display("fsk test done");
    endtask

    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        host.idle();
        t_reset();
        t_band();
        t_offset();
        t_retune();
        t_defer();
        t_fsk();
        results();
    end
endmodule // testbench
`default_nettype wire
